// File: hdcr_pkg.sv
package hdcr_pkg;

    localparam logic [7:0] OFS_PRODUCT_ID_HIGH = 8'h04;
    localparam logic [7:0] OFS_DEVICE_CONFIGURATION = 8'h05;
    localparam logic [7:0] OFS_CHARGE_SUPPORT_CONFIG = 8'h06;

    localparam int BIT_STRING_OVR = 7;
    localparam int BIT_SERIAL_OVR = 6;
    localparam int BIT_LP_DISABLE = 5;
    localparam int BIT_RSVD_ONE = 4;
    localparam int BIT_SHARED_SW = 3;
    localparam int BIT_REPORT_OFF = 2;
    localparam int BIT_TIMEOUT_OVR = 1;
    localparam int BIT_RSVD_ZERO = 0;

    localparam logic [7:0] DEVCFG_RESET = 8'h10;
    localparam logic [7:0] DEVCFG_WMASK = 8'hEE;
    localparam logic [7:0] DEVCFG_FIXED1 = 8'h10;
    localparam logic [7:0] CHARGE_WMASK = 8'h0F;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] TIMEOUT_MAX = 8'hFF;
    localparam logic [3:0] NIBBLE_ZERO = 4'h0;
    localparam logic [3:0] NIBBLE_ONES = 4'hF;

    localparam logic [1:0] STRAP_SETTLE = 2'h2;
    localparam logic [1:0] CNT_ONE = 2'h1;

    typedef enum logic
    {
        HDCR_SRC_EEPROM,
        HDCR_SRC_SMBUS
    } hdcr_src_t;

    typedef struct packed
    {
        logic wr;
        hdcr_src_t src;
        logic [7:0] addr;
        logic [7:0] wdata;
    } hdcr_write_t;

    typedef struct packed
    {
        logic shared_switch;
        logic power_report;
        logic [3:0] charge;
    } hdcr_straps_t;

endpackage

// File: hdcr_config_regs.sv
`timescale 1ns/1ps

//Contract
//- product high byte resets default, writable
//- report written, else otp, else default
//- bit 7 gates string register writes
//- bit 6 gates serial register writes
//- bit 5 blocks U1/U2 unless forced
//- forced accept holds until reset/disconnect
//- eeprom in i2c, smbus host in smbus
//- bit 4 reserved reads one
//- bit 3 captured from shared strap
//- bit 3 selects per-port or ganged power while bit 2 is zero (bit 2 set turns all ports on)
//- bit 2 captured from report strap
//- bit 2 zero enables status reporting
//- override maps nonzero timeout to FFh
//- bit 0 reserved reads zero
//- charge register bits 7:4 read zero
//- charge bit n enables port n+1
//- charge bits captured from strap pins
//- charge bits replaceable by eeprom/smbus
//- product high byte at offset 4h
module hdcr_config_regs
    import hdcr_pkg::*;
#(
    parameter int NUM_PORTS = 4,
    parameter logic [7:0] PRODUCT_HIGH_DEFAULT = 8'h5A
)
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic shared_switch_strap_pin,
    input wire logic power_report_strap_pin,
    input wire logic [NUM_PORTS-1:0] port_power_charge_pins,
    input wire logic i2c_mode,
    input wire logic smbus_mode,
    input wire hdcr_write_t cfg_write,
    input wire logic [7:0] cfg_rd_addr,
    input wire logic ids_written_nonzero,
    input wire logic [7:0] otp_product_high,
    input wire logic flpma_event,
    input wire logic upstream_disconnect,
    input wire logic [NUM_PORTS-1:0] port_power_request,
    input wire logic [7:0] host_link_timeout,
    output logic [7:0] cfg_rdata,
    output logic [7:0] product_code_high_byte,
    output logic string_override_enable,
    output logic serial_override_enable,
    output logic low_power_link_allow,
    output logic power_status_report_on,
    output logic [NUM_PORTS-1:0] port_power_control_pins,
    output logic [NUM_PORTS-1:0] charge_port_enable,
    output logic [7:0] link_timeout_effective
);

    typedef struct packed
    {
        hdcr_straps_t sync1;
        hdcr_straps_t sync2;
        logic [1:0] settle;
        logic captured;
        logic [7:0] pid_high;
        logic [7:0] devcfg;
        logic [3:0] charge;
        logic flpma_seen;
        logic [7:0] rdata;
        logic [7:0] pid_report;
        logic string_ovr;
        logic serial_ovr;
        logic lp_allow;
        logic report_on;
        logic [NUM_PORTS-1:0] pwr_en;
        logic [NUM_PORTS-1:0] charge_en;
        logic [7:0] timeout_eff;
    } hdcr_state_t;

    hdcr_state_t state_q;
    hdcr_state_t state_d;

    localparam hdcr_state_t STATE_RESET = '{
        sync1: '0,
        sync2: '0,
        settle: '0,
        captured: 1'b0,
        pid_high: PRODUCT_HIGH_DEFAULT,
        devcfg: DEVCFG_RESET,
        charge: NIBBLE_ZERO,
        flpma_seen: 1'b0,
        rdata: BYTE_ZERO,
        pid_report: PRODUCT_HIGH_DEFAULT,
        string_ovr: 1'b0,
        serial_ovr: 1'b0,
        lp_allow: 1'b0,
        report_on: 1'b0,
        pwr_en: '0,
        charge_en: '0,
        timeout_eff: BYTE_ZERO
    };

    logic wr_ok;
    logic [7:0] devcfg_rd;
    logic [7:0] charge_rd;

    always_comb
    begin
        state_d = state_q;
        wr_ok = cfg_write.wr &&
            ((cfg_write.src == HDCR_SRC_EEPROM && i2c_mode) ||
             (cfg_write.src == HDCR_SRC_SMBUS && smbus_mode));

        state_d.sync1.shared_switch = shared_switch_strap_pin;
        state_d.sync1.power_report = power_report_strap_pin;
        state_d.sync1.charge = port_power_charge_pins[3:0];
        state_d.sync2 = state_q.sync1;

        if (!state_q.captured)
        begin
            if (state_q.settle == STRAP_SETTLE)
            begin
                state_d.captured = 1'b1;
                state_d.devcfg[BIT_SHARED_SW] = state_q.sync2.shared_switch;
                state_d.devcfg[BIT_REPORT_OFF] = state_q.sync2.power_report;
                state_d.charge = state_q.sync2.charge;
            end
            else
            begin
                state_d.settle = state_q.settle + CNT_ONE;
            end
        end

        if (wr_ok)
        begin
            case (cfg_write.addr)
                OFS_PRODUCT_ID_HIGH:
                begin
                    state_d.pid_high = cfg_write.wdata;
                end
                OFS_DEVICE_CONFIGURATION:
                begin
                    state_d.devcfg = (cfg_write.wdata & DEVCFG_WMASK) | DEVCFG_FIXED1;
                end
                OFS_CHARGE_SUPPORT_CONFIG:
                begin
                    state_d.charge = cfg_write.wdata[3:0];
                end
                default:
                begin
                    state_d.charge = state_d.charge;
                end
            endcase
        end

        if (upstream_disconnect)
        begin
            state_d.flpma_seen = 1'b0;
        end
        else if (flpma_event)
        begin
            state_d.flpma_seen = 1'b1;
        end

        devcfg_rd = (state_q.devcfg & DEVCFG_WMASK) | DEVCFG_FIXED1;
        charge_rd = {NIBBLE_ZERO, state_q.charge};

        case (cfg_rd_addr)
            OFS_PRODUCT_ID_HIGH:
            begin
                state_d.rdata = state_q.pid_high;
            end
            OFS_DEVICE_CONFIGURATION:
            begin
                state_d.rdata = devcfg_rd;
            end
            OFS_CHARGE_SUPPORT_CONFIG:
            begin
                state_d.rdata = charge_rd & CHARGE_WMASK;
            end
            default:
            begin
                state_d.rdata = BYTE_ZERO;
            end
        endcase

        if (ids_written_nonzero)
        begin
            state_d.pid_report = state_q.pid_high;
        end
        else if (otp_product_high != BYTE_ZERO)
        begin
            state_d.pid_report = otp_product_high;
        end
        else
        begin
            state_d.pid_report = PRODUCT_HIGH_DEFAULT;
        end

        state_d.string_ovr = state_q.devcfg[BIT_STRING_OVR];
        state_d.serial_ovr = state_q.devcfg[BIT_SERIAL_OVR];
        state_d.lp_allow = !state_q.devcfg[BIT_LP_DISABLE] || state_q.flpma_seen;
        state_d.report_on = !state_q.devcfg[BIT_REPORT_OFF];

        for (int i = 0; i < NUM_PORTS; i++)
        begin
            if (state_q.devcfg[BIT_REPORT_OFF])
            begin
                state_d.pwr_en[i] = 1'b1;
            end
            else if (state_q.devcfg[BIT_SHARED_SW])
            begin
                state_d.pwr_en[i] = port_power_request[0];
            end
            else
            begin
                state_d.pwr_en[i] = port_power_request[i];
            end
            state_d.charge_en[i] = state_q.charge[i];
        end

        if (state_q.devcfg[BIT_TIMEOUT_OVR] && host_link_timeout != BYTE_ZERO)
        begin
            state_d.timeout_eff = TIMEOUT_MAX;
        end
        else
        begin
            state_d.timeout_eff = host_link_timeout;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            state_q <= STATE_RESET;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    assign cfg_rdata = state_q.rdata;
    assign product_code_high_byte = state_q.pid_report;
    assign string_override_enable = state_q.string_ovr;
    assign serial_override_enable = state_q.serial_ovr;
    assign low_power_link_allow = state_q.lp_allow;
    assign power_status_report_on = state_q.report_on;
    assign port_power_control_pins = state_q.pwr_en;
    assign charge_port_enable = state_q.charge_en;
    assign link_timeout_effective = state_q.timeout_eff;

endmodule

// File: hdcr_config_regs_properties.sv
`timescale 1ns/1ps
module hdcr_config_regs_properties
    import hdcr_pkg::*;
#(
    parameter int NUM_PORTS = 4,
    parameter logic [7:0] PRODUCT_HIGH_DEFAULT = 8'h5A
)
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [7:0] cfg_rd_addr,
    input wire logic [7:0] cfg_rdata,
    input wire logic ids_written_nonzero,
    input wire logic [7:0] otp_product_high,
    input wire logic flpma_event,
    input wire logic upstream_disconnect,
    input wire logic [NUM_PORTS-1:0] port_power_request,
    input wire logic [7:0] host_link_timeout,
    input wire logic [7:0] product_code_high_byte,
    input wire logic string_override_enable,
    input wire logic serial_override_enable,
    input wire logic low_power_link_allow,
    input wire logic power_status_report_on,
    input wire logic [NUM_PORTS-1:0] port_power_control_pins,
    input wire logic [NUM_PORTS-1:0] charge_port_enable,
    input wire logic [7:0] link_timeout_effective
);
    logic dev_q;
    logic chg_q;
    always_ff @(posedge sys_clk)
    begin
        dev_q <= !reset && cfg_rd_addr == OFS_DEVICE_CONFIGURATION;
        chg_q <= !reset && cfg_rd_addr == OFS_CHARGE_SUPPORT_CONFIG;
    end
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);
    a_rsvd_bits: assert property (dev_q |-> cfg_rdata[4] && !cfg_rdata[0]) else $error("rsvd");
    a_charge_read: assert property (chg_q |-> cfg_rdata == {4'h0, charge_port_enable}) else $error("chg");
    a_dev_flags: assert property (dev_q |-> cfg_rdata[7:6] == {string_override_enable, serial_override_enable}
        && cfg_rdata[2] != power_status_report_on) else $error("flags");
    a_timeout_map: assert property (dev_q |-> link_timeout_effective ==
        (cfg_rdata[1] && $past(host_link_timeout) != 8'h00 ? TIMEOUT_MAX : $past(host_link_timeout))) else $error("tmo");
    a_lp_blocked: assert property (dev_q && cfg_rdata[5] && $past(upstream_disconnect, 2)
        |-> !low_power_link_allow) else $error("lp");
    a_forced_hold: assert property (flpma_event && !upstream_disconnect |-> ##2 low_power_link_allow) else $error("fl");
    a_port_power: assert property (dev_q && !cfg_rdata[2] |-> port_power_control_pins ==
        (cfg_rdata[3] ? {NUM_PORTS{$past(port_power_request[0])}} : $past(port_power_request))) else $error("pwr");
    a_pid_source: assert property (!$past(reset) && !$past(ids_written_nonzero) |-> product_code_high_byte ==
        ($past(otp_product_high) != 8'h00 ? $past(otp_product_high) : PRODUCT_HIGH_DEFAULT)) else $error("pid");
endmodule

bind hdcr_config_regs hdcr_config_regs_properties #(.NUM_PORTS(NUM_PORTS), .PRODUCT_HIGH_DEFAULT(PRODUCT_HIGH_DEFAULT))
    u_props (.sys_clk, .reset, .cfg_rd_addr, .cfg_rdata, .ids_written_nonzero, .otp_product_high, .flpma_event,
    .upstream_disconnect, .port_power_request, .host_link_timeout, .product_code_high_byte, .string_override_enable,
    .serial_override_enable, .low_power_link_allow, .power_status_report_on, .port_power_control_pins,
    .charge_port_enable, .link_timeout_effective);

// File: hdcr_host_model.sv
`timescale 1ns/1ps
module hdcr_host_model
    import hdcr_pkg::*;
(
    input wire logic sys_clk,
    output hdcr_write_t cfg_write
);
    initial cfg_write = '0;
    // one byte per call; released bus shows inverted values
    task automatic put(input hdcr_src_t s, input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        cfg_write <= '{1'b1, s, a, d};
        @(posedge sys_clk);
        cfg_write <= '{1'b0, s, ~a, ~d};
    endtask
endmodule

// File: tb.sv
`timescale 1ns/1ps
module tb;
    import hdcr_pkg::*;
    localparam logic [7:0] PHD = 8'h5A; // arbitrary product code
    logic sys_clk = 0, reset = 1, sh = 1, rp = 0, i2c = 0, smb = 1, idw = 0, fl = 0, dis = 0;
    logic [3:0] chg = 4'hA, req = 4'h1, pins, cen;
    logic [7:0] rda = 8'h00, otp = 8'h00, host = 8'h00, rdata, pid, tmo;
    logic so, se, lpa, pro;
    hdcr_write_t cw;
    int mismatches = 0, comparisons = 0, cycles = 0;
    always #25 sys_clk = ~sys_clk;
    hdcr_host_model u_hdcr_host_model (.sys_clk(sys_clk), .cfg_write(cw));
    hdcr_config_regs #(.PRODUCT_HIGH_DEFAULT(PHD)) u_hdcr_config_regs (.sys_clk(sys_clk), .reset(reset),
        .shared_switch_strap_pin(sh), .power_report_strap_pin(rp), .port_power_charge_pins(chg), .i2c_mode(i2c),
        .smbus_mode(smb), .cfg_write(cw), .cfg_rd_addr(rda), .ids_written_nonzero(idw), .otp_product_high(otp),
        .flpma_event(fl), .upstream_disconnect(dis), .port_power_request(req), .host_link_timeout(host),
        .cfg_rdata(rdata), .product_code_high_byte(pid), .string_override_enable(so), .serial_override_enable(se),
        .low_power_link_allow(lpa), .power_status_report_on(pro), .port_power_control_pins(pins),
        .charge_port_enable(cen), .link_timeout_effective(tmo));
    task automatic conclude();
        if (mismatches == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        comparisons++;
        if (s !== e)
        begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk) rda <= a;
        repeat (2) @(posedge sys_clk);
        #1 chk("rdata", rdata, e);
    endtask
    task automatic wt();
        repeat (3) @(posedge sys_clk);
        #1;
    endtask
    always @(posedge sys_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            mismatches++;
            conclude();
        end
    end
    initial
    begin
        repeat (8) @(posedge sys_clk);
        reset <= 0;
        repeat (6) @(posedge sys_clk);
        rd(OFS_CHARGE_SUPPORT_CONFIG, 8'h0A);
        rd(OFS_PRODUCT_ID_HIGH, PHD);
        rd(8'h07, 8'h00);
        rd(OFS_DEVICE_CONFIGURATION, 8'h18);
        chk("charge", 8'(cen), 8'h0A);
        chk("ports", 8'(pins), 8'h0F);
        @(posedge sys_clk) req <= 4'hE;
        wt();
        chk("ports", 8'(pins), 8'h00);
        u_hdcr_host_model.put(HDCR_SRC_SMBUS, OFS_DEVICE_CONFIGURATION, 8'hFF);
        rd(OFS_DEVICE_CONFIGURATION, 8'hFE);
        chk("flags", {so, se, lpa, pro, pins}, 8'hCF);
        @(posedge sys_clk) host <= 8'h01;
        wt();
        chk("tmo", tmo, 8'hFF);
        @(posedge sys_clk) host <= 8'h00;
        wt();
        chk("tmo", tmo, 8'h00);
        @(posedge sys_clk) fl <= 1;
        @(posedge sys_clk) fl <= 0;
        wt();
        chk("lp", 8'(lpa), 8'h01);
        @(posedge sys_clk) dis <= 1;
        @(posedge sys_clk) dis <= 0;
        wt();
        chk("lp", 8'(lpa), 8'h00);
        u_hdcr_host_model.put(HDCR_SRC_EEPROM, OFS_CHARGE_SUPPORT_CONFIG, 8'hF5);
        rd(OFS_CHARGE_SUPPORT_CONFIG, 8'h0A);
        @(posedge sys_clk) i2c <= 1;
        u_hdcr_host_model.put(HDCR_SRC_EEPROM, OFS_CHARGE_SUPPORT_CONFIG, 8'hF5);
        rd(OFS_CHARGE_SUPPORT_CONFIG, 8'h05);
        chk("charge", 8'(cen), 8'h05);
        u_hdcr_host_model.put(HDCR_SRC_SMBUS, OFS_PRODUCT_ID_HIGH, 8'h77);
        @(posedge sys_clk) idw <= 1;
        otp <= 8'h33;
        rd(OFS_PRODUCT_ID_HIGH, 8'h77);
        chk("pid", pid, 8'h77);
        @(posedge sys_clk) idw <= 0;
        wt();
        chk("pid", pid, 8'h33);
        @(posedge sys_clk) otp <= 8'h00;
        wt();
        chk("pid", pid, PHD);
        conclude();
    end
endmodule
